// ===== testbench/clock_ctrl_monitor.sv
// assertions on the clock control ports
// assumes one clock and synchronous reset
`timescale 1ns/1ps
`default_nettype none
module clock_ctrl_monitor #(
  parameter int unsigned MASK_W = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic low_power_stop_instr_i,
  input wire logic [MASK_W-1:0] cpu_mask_i,
  input wire logic [MASK_W-1:0] pit_irq_level_i,
  input wire logic [MASK_W-1:0] ext_irq_level_i,
  input wire logic breakpoint_i,
  input wire logic background_mode_i,
  input wire logic core_reset_o,
  input wire logic stop_o,
  input wire logic freeze_o,
  input wire logic bus_monitor_en_o,
  input wire logic halt_monitor_en_o,
  input wire logic watchdog_clk_en_o,
  input wire logic pit_clk_en_o,
  input wire logic [5:0] modulus_o,
  input wire logic [8:0] sys_mult_o
);
  logic [MASK_W-1:0] mask_q;
  always_ff @(posedge clk_i) if (low_power_stop_instr_i && !stop_o) mask_q <= cpu_mask_i;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////
  stop_entry_a: assert property (low_power_stop_instr_i && !stop_o && !core_reset_o |=> stop_o)
    else $error("no stop");
  mon_off_a: assert property (stop_o && $past(stop_o) |-> !bus_monitor_en_o && !halt_monitor_en_o)
    else $error("monitor on in stop");
  wdog_gate_a: assert property (stop_o && $past(stop_o) |-> !watchdog_clk_en_o)
    else $error("watchdog runs in stop");
  pit_runs_a: assert property (stop_o && $past(stop_o) && !freeze_o && !$past(freeze_o) |-> pit_clk_en_o)
    else $error("timer halted in stop");
  stop_wake_a: assert property (stop_o && (pit_irq_level_i > mask_q || ext_irq_level_i > mask_q) |=> !stop_o)
    else $error("no wake");
  freeze_set_a: assert property (breakpoint_i && background_mode_i |=> freeze_o)
    else $error("no freeze");
  halt_kept_a: assert property (freeze_o && $past(freeze_o) && !stop_o &&
    !$past(stop_o) && !core_reset_o |-> halt_monitor_en_o) else $error("halt monitor off");
  mult_track_a: assert property (sys_mult_o == 9'(4 * (modulus_o + 1)))
    else $error("multiplier wrong");
  cover property ($fell(stop_o));
  cover property (freeze_o && !bus_monitor_en_o);
  cover property (stop_o && !watchdog_clk_en_o);
endmodule
bind clock_synth_stop_freeze_ctrl clock_ctrl_monitor #(.MASK_W(MASK_W)) clock_ctrl_monitor_inst (.clk_i, .rst_i,
  .low_power_stop_instr_i, .cpu_mask_i, .pit_irq_level_i, .ext_irq_level_i, .breakpoint_i, .background_mode_i,
  .core_reset_o, .stop_o, .freeze_o, .bus_monitor_en_o, .halt_monitor_en_o, .watchdog_clk_en_o, .pit_clk_en_o,
  .modulus_o, .sys_mult_o);
`default_nettype wire

// ===== testbench/clock_synth_stop_freeze_ctrl_tb.sv
// bench for the clock control block: register model, bus tasks, scenarios
// assumes the design, partner and monitor are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "clock_ctrl_consts.svh"
module clock_synth_stop_freeze_ctrl_tb;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, go = 1'b0;
  logic [3:0] adr_i = 4'h0, sel_i = 4'h3;
  logic [31:0] dat_i = 32'h0000_0000, dat_o, rd, seed = 32'hfd3e_eaa3;
  logic ack_o, clock_source_select_pin_i = 1'b1, low_power_stop_instr_i, breakpoint_i = 1'b0;
  logic background_mode_i = 1'b0, core_reset_o, stop_o, clocks_gated_o, freeze_o, bus_monitor_en_o;
  logic halt_monitor_en_o, spurious_monitor_en_o, watchdog_clk_en_o, pit_clk_en_o, synth_enable_o, out_div2_o;
  logic [2:0] cpu_mask_i, pit_irq_level_i = 3'h0, ext_irq_level_i = 3'h0, prescale_o, m = 3'h0;
  logic [5:0] modulus_o;
  logic [8:0] sys_mult_o;
  int miscompares = 0, total_checks = 0, synth_m = 'h3f00, d, rl, mk;
  clock_synth_stop_freeze_ctrl #(.RELOCK_CYCLES(8)) clock_synth_stop_freeze_ctrl_inst (.clk_i, .rst_i, .cyc_i,
    .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .clock_source_select_pin_i, .low_power_stop_instr_i,
    .cpu_mask_i, .pit_irq_level_i, .ext_irq_level_i, .breakpoint_i, .background_mode_i, .core_reset_o, .stop_o,
    .clocks_gated_o, .freeze_o, .bus_monitor_en_o, .halt_monitor_en_o, .spurious_monitor_en_o,
    .watchdog_clk_en_o, .pit_clk_en_o, .synth_enable_o, .prescale_o, .modulus_o, .out_div2_o, .sys_mult_o);
  core_partner core_partner_inst (.clk_i, .stop_req_i(go), .mask_i(m), .stop_instr_o(low_power_stop_instr_i),
    .mask_o(cpu_mask_i));
  always #10 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [18:0] outs(input int s);
    return {s[15] ? 3'h7 : 3'h0, 6'(s[13:8]), !s[14], 9'(4 * (s[13:8] + 1))};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input int v);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, 32'(v)};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    {cyc_i, stb_i} <= 2'b00;
  endtask
  task automatic report_and_stop;
    $display("total_checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #50_000;
    miscompares++;
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 40 && core_reset_o !== 1'b0; i++) @(posedge clk_i);
    step(1);
    chk(core_reset_o, 0);
    wb(0, `OFS_SYNTH_CTRL, 0);
    chk(rd & 'hff08, 'h3f08);
    chk({prescale_o, modulus_o, out_div2_o, sys_mult_o}, outs(synth_m));
    wb(0, 4'h2, 0);
    chk(rd, 0);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      d = (i == 3) ? synth_m ^ 'h4000 : seed[15:0] | 'h8;
      rl = (d ^ synth_m) & 'hbf00;
      synth_m = d;
      wb(1, `OFS_SYNTH_CTRL, d);
      wb(0, `OFS_SYNTH_CTRL, 0);
      chk(rd & 'hff08, (d & 'hff00) | (rl ? 0 : 8));
      step(12);
      wb(0, `OFS_SYNTH_CTRL, 0);
      chk(rd & 'hff08, (d & 'hff00) | 8);
      chk({prescale_o, modulus_o, out_div2_o, sys_mult_o}, outs(d));
    end
    for (int i = 0; i < 2; i++) begin
      wb(1, `OFS_MODULE_CFG, i ? 0 : 'h10);
      wb(1, `OFS_PIT, 0);
      seed = lfsr(seed);
      mk = seed[1:0];
      {m, go} <= {3'(mk), 1'b1};
      step(1);
      go <= 1'b0;
      step(3);
      chk({stop_o, clocks_gated_o, watchdog_clk_en_o, halt_monitor_en_o, bus_monitor_en_o, spurious_monitor_en_o,
        pit_clk_en_o}, {1'b1, i == 0, 5'b00001});
      {m, ext_irq_level_i} <= {3'h7, 3'(mk)};
      step(3);
      chk(stop_o, 1);
      {pit_irq_level_i, ext_irq_level_i} <= i ? {3'h0, 3'(mk + 1)} : {3'(mk + 1), 3'h0};
      step(3);
      chk({stop_o, watchdog_clk_en_o, halt_monitor_en_o}, 3'b011);
      {pit_irq_level_i, ext_irq_level_i} <= 6'h00;
    end
    for (int i = 0; i < 3; i++) begin
      wb(1, `OFS_MODULE_CFG, i == 0 ? 'h40 : i == 1 ? 'h80 : 0);
      {breakpoint_i, background_mode_i} <= 2'b11;
      step(3);
      chk({freeze_o, bus_monitor_en_o, watchdog_clk_en_o, pit_clk_en_o, halt_monitor_en_o},
        {1'b1, i != 0, i != 1, i != 1, 1'b1});
      background_mode_i <= 1'b0;
      step(2);
      chk(freeze_o, 0);
    end
    {rst_i, clock_source_select_pin_i, breakpoint_i} <= 3'b100;
    step(2);
    rst_i <= 1'b0;
    step(12);
    chk({synth_enable_o, core_reset_o}, 2'b00);
    wb(1, `OFS_SYNTH_CTRL, 'h0100);
    wb(0, `OFS_STATUS, 0);
    chk(rd[2:1], 2'b01);
    report_and_stop();
  end
endmodule
`default_nettype wire

// ===== testbench/core_partner.sv
// processor core stand-in: issues the stop instruction and drives the priority mask
// assumes the bench raises stop_req_i for one cycle per stop
`timescale 1ns/1ps
`default_nettype none
module core_partner (
  input wire logic clk_i,
  input wire logic stop_req_i,
  input wire logic [2:0] mask_i,
  output var logic stop_instr_o = 1'b0,
  output var logic [2:0] mask_o = 3'h0
);
  always @(posedge clk_i) begin
    stop_instr_o <= stop_req_i;
    mask_o <= mask_i;
  end
endmodule
`default_nettype wire

// ===== verilog/clock_ctrl_consts.svh
// constants for the clock control block: register offsets, fields, resets, timing
// assumes inclusion by bare name from the bench and the design file
`ifndef CLOCK_CTRL_CONSTS_SVH
`define CLOCK_CTRL_CONSTS_SVH
`define OFS_SYNTH_CTRL 4'h0
`define OFS_MODULE_CFG 4'h4
`define OFS_PIT 4'h8
`define OFS_STATUS 4'hc
`define SYNTH_CTRL_RESET 16'h3f00
`define SYNTH_MULT_RESET 9'h100
`define SYNTH_W_BIT 15
`define SYNTH_X_BIT 14
`define SYNTH_Y_MSB 13
`define SYNTH_Y_LSB 8
`define SYNTH_LOCK_BIT 3
`define CFG_FREEZE_WATCHDOG_DISABLE_BIT 7
`define CFG_FREEZE_BUS_MONITOR_DISABLE_BIT 6
`define CFG_STOPSEL_BIT 4
`define MODULE_CFG_RESET 16'h0000
`define PIT_RESET 16'h0000
`define RELOCK_NS 20000
`define RELOCK_CYCLES ((`RELOCK_NS + 19) / 20)
`endif

// ===== verilog/clock_ctrl_pkg.sv
// types shared by the clock control block
// assumes the constants header is on the include path
package clock_ctrl_pkg;
  typedef enum logic [2:0] {
    ST_RESET_HOLD = 3'b001,
    ST_RUN = 3'b010,
    ST_STOP = 3'b100
  } mode_t;
endpackage

// ===== verilog/clock_synth_stop_freeze_ctrl.sv
// system clock control: synthesizer control register, lock tracking, low-power stop, freeze gating
// assumes a classic wishbone master on clk_i; the core and peripherals sit on the plain ports
// How it works
// - on stop instruction, latch priority mask and gate clocks per stop-clock select bit
// - bus, halt and spurious interrupt monitors are inactive during stop
// - watchdog clock gated in stop, keeps count, resumes next edge after stop
// - periodic timer keeps counting through stop, ignoring the stop instruction
// - stop ends on timer or external interrupt above latched mask, or reset
// - freeze asserted on breakpoint while background debug is enabled
// - freeze touches only bus monitor, watchdog and periodic timer
// - freeze-bus-monitor bit disables the bus monitor while freeze holds
// - freeze-watchdog bit disables watchdog and periodic timer while freeze holds
// - rate changes never disturb register contents
// - clock-source pin sampled in reset; low disables synthesizer and its controls (here prescale_o, modulus_o, out_div2_o still follow writes)
// - oscillator runs at two or four times system clock per output-divider bit
// - read-only lock flag reports lock; any comparator input change forces relock
// - device held in reset until synthesizer reports lock at power-up
// - prescale bit drives a three-bit feedback prescaler, multiplying oscillator by four
// - modulus field programs modulo-64 down counter dividing by value plus one
// - writing prescale or modulus changes oscillator and costs a relock delay
// - output-divider bit resets to zero; setting it doubles clock without relock
// - system clock equals reference times 4, modulus plus one, 2 to 2W+X
// - synthesizer control register resets to 0x3f00, modulus-64 count
`include "clock_ctrl_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module clock_synth_stop_freeze_ctrl
  import clock_ctrl_pkg::*;
#(
  parameter int unsigned RELOCK_CYCLES = `RELOCK_CYCLES,
  parameter int unsigned MASK_W = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic clock_source_select_pin_i,
  input wire logic low_power_stop_instr_i,
  input wire logic [MASK_W-1:0] cpu_mask_i,
  input wire logic [MASK_W-1:0] pit_irq_level_i,
  input wire logic [MASK_W-1:0] ext_irq_level_i,
  input wire logic breakpoint_i,
  input wire logic background_mode_i,
  output logic core_reset_o,
  output logic stop_o,
  output logic clocks_gated_o,
  output logic freeze_o,
  output logic bus_monitor_en_o,
  output logic halt_monitor_en_o,
  output logic spurious_monitor_en_o,
  output logic watchdog_clk_en_o,
  output logic pit_clk_en_o,
  output logic synth_enable_o,
  output logic [2:0] prescale_o,
  output logic [5:0] modulus_o,
  output logic out_div2_o,
  output logic [8:0] sys_mult_o
);

  initial begin
    if (MASK_W != 3) begin
      $error("mask width must be 3");
    end
    if (RELOCK_CYCLES < 1 || RELOCK_CYCLES > 32'h00ff_ffff) begin
      $error("relock count out of range");
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    mode_t mode;
    logic [15:0] synth;
    logic [15:0] cfg;
    logic [15:0] periodic_interrupt_timer;
    logic synth_en;
    logic locked;
    logic [23:0] lock_cnt;
    logic [MASK_W-1:0] mask;
    logic freeze;
    logic ack;
    logic [31:0] rdata;
    logic [8:0] mult;
    logic bm_en;
    logic wd_en;
    logic pit_en;
    logic gated;
    logic sampled;
  } state_t;

  state_t s_q, s_d;

  logic req;
  logic wr_synth;
  logic [15:0] wdat;
  logic relock;
  logic wake;
  logic frz_next;

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_d = s_q;
    req = cyc_i && stb_i && !s_q.ack;
    wdat = dat_i[15:0];
    wr_synth = req && we_i && (adr_i == `OFS_SYNTH_CTRL);
    relock = 1'b0;
    s_d.ack = req;
    s_d.rdata = 32'h0000_0000;
    if (req && !we_i) begin
      if (adr_i == `OFS_SYNTH_CTRL) begin
        s_d.rdata[15:0] = s_q.synth;
        s_d.rdata[`SYNTH_LOCK_BIT] = s_q.locked;
      end else if (adr_i == `OFS_MODULE_CFG) begin
        s_d.rdata[15:0] = s_q.cfg;
      end else if (adr_i == `OFS_PIT) begin
        s_d.rdata[15:0] = s_q.periodic_interrupt_timer;
      end else if (adr_i == `OFS_STATUS) begin
        s_d.rdata[4:0] = {s_q.freeze, s_q.mode == ST_STOP, s_q.synth_en, s_q.locked, s_q.gated};
      end else begin
        s_d.rdata = 32'h0000_0000;
      end
    end
    if (req && we_i) begin
      if (adr_i == `OFS_SYNTH_CTRL) begin
        if (sel_i[1]) begin
          s_d.synth[15:8] = wdat[15:8];
        end
        if (sel_i[0]) begin
          s_d.synth[7:0] = wdat[7:0] & 8'hf7;
        end
        if (sel_i[1] && (wdat[15] != s_q.synth[15] || wdat[13:8] != s_q.synth[13:8])) begin
          relock = s_q.synth_en;
        end
      end else if (adr_i == `OFS_MODULE_CFG) begin
        if (sel_i[1]) begin
          s_d.cfg[15:8] = wdat[15:8];
        end
        if (sel_i[0]) begin
          s_d.cfg[7:0] = wdat[7:0];
        end
      end else if (adr_i == `OFS_PIT) begin
        if (sel_i[1]) begin
          s_d.periodic_interrupt_timer[15:8] = wdat[15:8];
        end
        if (sel_i[0]) begin
          s_d.periodic_interrupt_timer[7:0] = wdat[7:0];
        end
      end
    end
    // lock tracking; disabled synthesizer counts as locked
    if (!s_q.sampled) begin
      s_d.sampled = 1'b1;
      s_d.synth_en = clock_source_select_pin_i;
      s_d.locked = !clock_source_select_pin_i;
      s_d.lock_cnt = 24'h00_0000;
    end else if (!s_q.synth_en) begin
      s_d.locked = 1'b1;
      s_d.lock_cnt = 24'h00_0000;
    end else if (relock) begin
      s_d.locked = 1'b0;
      s_d.lock_cnt = 24'h00_0000;
    end else if (!s_q.locked) begin
      if (s_q.lock_cnt >= 24'(RELOCK_CYCLES - 1)) begin
        s_d.locked = 1'b1;
      end else begin
        s_d.lock_cnt = s_q.lock_cnt + 24'h00_0001;
      end
    end
    // output divider change keeps lock
    s_d.mult = 9'(({3'b000, s_d.synth[`SYNTH_Y_MSB:`SYNTH_Y_LSB]} + 9'h001) << 2);
    frz_next = breakpoint_i && background_mode_i;
    s_d.freeze = frz_next;
    wake = (pit_irq_level_i > s_q.mask) || (ext_irq_level_i > s_q.mask);
    case (s_q.mode)
      ST_RESET_HOLD: begin
        if (s_d.locked && s_q.locked) begin
          s_d.mode = ST_RUN;
        end
      end
      ST_RUN: begin
        if (low_power_stop_instr_i) begin
          s_d.mode = ST_STOP;
          s_d.mask = cpu_mask_i;
        end
      end
      ST_STOP: begin
        if (wake) begin
          s_d.mode = ST_RUN;
        end
      end
      default: begin
        s_d.mode = ST_RESET_HOLD;
      end
    endcase
    s_d.gated = (s_d.mode == ST_STOP) && s_q.cfg[`CFG_STOPSEL_BIT];
    s_d.bm_en = (s_d.mode == ST_RUN) && !(frz_next && s_q.cfg[`CFG_FREEZE_BUS_MONITOR_DISABLE_BIT]);
    s_d.wd_en = (s_d.mode == ST_RUN) && !(frz_next && s_q.cfg[`CFG_FREEZE_WATCHDOG_DISABLE_BIT]);
    s_d.pit_en = (s_d.mode != ST_RESET_HOLD) && !(frz_next && s_q.cfg[`CFG_FREEZE_WATCHDOG_DISABLE_BIT]);
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers; rate changes never touch stored values
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.mode <= ST_RESET_HOLD;
      s_q.synth <= `SYNTH_CTRL_RESET;
      s_q.cfg <= `MODULE_CFG_RESET;
      s_q.periodic_interrupt_timer <= `PIT_RESET;
      s_q.synth_en <= 1'b0;
      s_q.locked <= 1'b0;
      s_q.mult <= `SYNTH_MULT_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  assign dat_o = s_q.rdata;
  assign ack_o = s_q.ack;
  assign core_reset_o = s_q.mode[0];
  assign stop_o = s_q.mode[2];
  assign clocks_gated_o = s_q.gated;
  assign freeze_o = s_q.freeze;
  assign bus_monitor_en_o = s_q.bm_en;
  assign halt_monitor_en_o = s_q.mode[1];
  assign spurious_monitor_en_o = s_q.mode[1];
  assign watchdog_clk_en_o = s_q.wd_en;
  assign pit_clk_en_o = s_q.pit_en;
  assign synth_enable_o = s_q.synth_en;
  assign prescale_o = s_q.synth[`SYNTH_W_BIT] ? 3'h7 : 3'h0;
  assign modulus_o = s_q.synth[`SYNTH_Y_MSB:`SYNTH_Y_LSB];
  assign out_div2_o = !s_q.synth[`SYNTH_X_BIT];
  assign sys_mult_o = s_q.mult;

endmodule
`default_nettype wire
